// ### rtl/adsf_pkg.sv
// Package: register map, field layout, reset values and timing of the converter block
package adsf_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_STATUS      = 8'h00;
    localparam logic [7:0] ADDR_TEST        = 8'h04;
    localparam logic [7:0] ADDR_PORT        = 8'h08;
    localparam logic [7:0] ADDR_POWER       = 8'h0c;
    localparam logic [7:0] ADDR_SEQ         = 8'h10;
    localparam logic [2:0] ADDR_RESULT_TAG  = 3'h1;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int STAT_SEQ_DONE_BIT  = 15;
    localparam int TEST_SOFT_RST_BIT  = 10;
    localparam int TEST_MUX_BIT       = 11;
    localparam int TEST_SEL_LSB       = 12;
    localparam int PWR_UP_BIT         = 0;
    localparam int PWR_FAST_CLR_BIT   = 1;
    localparam int PWR_STOP_WAIT_BIT  = 2;
    localparam int SEQ_SCAN_BIT       = 0;
    localparam int SEQ_EIGHT_BIT      = 1;

    // ****************************************
    // Reset and conversion start values
    // ****************************************
    localparam logic [2:0] PWR_RESET      = 3'h0;
    localparam logic [1:0] SEQ_RESET      = 2'h0;
    localparam logic [3:0] TEST_SEL_RESET = 4'h0;
    localparam logic [9:0] SAR_START      = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT    = 4'h9;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS       = 10;
    localparam int STOP_RECOVERY_NS    = 20000;
    localparam int STOP_RECOVERY_CYCLES =
        (STOP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] RECOVERY_LOAD = 12'(STOP_RECOVERY_CYCLES);
    localparam logic [2:0]  STEP_LAST     = 3'h3;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_RECOVER,
        SQ_CONVERT
    } adsf_sq_state_t;

endpackage

// ### rtl/adsf_top.sv
// Converter status, flags, test, port input and result registers behind AHB-Lite
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Sequence flag sets at first sequence end
// - Slow mode: flag cleared by sequence write
// - Fast mode: flag cleared reading result zero
// - Status shows three-bit conversion pointer
// - One channel flag per result register
// - Fast mode: result read clears its flag
// - Slow mode: status read then result read
// - Status flags writable in special mode only
// - Test register zero and locked when normal
// - Test field reads/loads ten-bit approximation
// - Soft reset clears all but power-up and results
// - Four-bit factory test select plus mux
// - Port register reads pins, ignores writes
// - Results left-justified, read-only, no reset
// - Stop aborts; recovery delay before restart
// - Wait halts only when stop-in-wait set
// - Power-up low halts, registers stay reachable
// - Sequence write restarts and clears flags
// - Eight-channel select picks four or eight
// - Scan bit picks single or repeated
module adsf_top (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire logic                  specialMode,
    input  wire logic                  stopReq,
    input  wire logic                  waitReq,
    input  wire logic [7:0]            portPins,
    input  wire logic                  compHigh,
    output logic [9:0]                 dacValue,
    output logic [2:0]                 channelSel,
    output logic                       converting,
    output logic [3:0]                 testSelect,
    output logic                       testOutMux
);
    import adsf_pkg::*;
    function automatic logic [9:0] bitMask(input logic [3:0] idx);
        bitMask = 10'h001 << idx;
    endfunction
    function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] off);
        hitAddr = (a == off);
    endfunction
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [7:0]     portMeta_reg;
    logic [7:0]     portSync_reg;
    logic           compMeta_reg;
    logic           compSync_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            portMeta_reg <= 8'h00;
            portSync_reg <= 8'h00;
            compMeta_reg <= 1'b0;
            compSync_reg <= 1'b0;
        end else begin
            portMeta_reg <= portPins;
            portSync_reg <= portMeta_reg;
            compMeta_reg <= compHigh;
            compSync_reg <= compMeta_reg;
        end
    end
    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic           dpValid_reg;
    logic           dpWrite_reg;
    logic [7:0]     dpAddr_reg;
    logic           hreadyout_reg;
    logic [31:0]    hrdata_reg;
    logic [31:0]    readMux;

    wire addrTake  = hsel & hready & htrans[1];
    wire wrStrobe  = dpValid_reg & dpWrite_reg;
    wire rdStrobe  = dpValid_reg & ~dpWrite_reg;
    wire [2:0] dpIdx = dpAddr_reg[4:2];
    wire isStatus  = hitAddr(dpAddr_reg, ADDR_STATUS);
    wire isTest    = hitAddr(dpAddr_reg, ADDR_TEST);
    wire isPort    = hitAddr(dpAddr_reg, ADDR_PORT);
    wire isPower   = hitAddr(dpAddr_reg, ADDR_POWER);
    wire isSeq     = hitAddr(dpAddr_reg, ADDR_SEQ);
    wire isResult  = (dpAddr_reg[7:5] == ADDR_RESULT_TAG);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dpValid_reg   <= 1'b0;
            dpWrite_reg   <= 1'b0;
            dpAddr_reg    <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h0000_0000;
        end else begin
            dpValid_reg   <= addrTake;
            dpWrite_reg   <= hwrite;
            dpAddr_reg    <= addrTake ? haddr[7:0] : dpAddr_reg;
            // Reads take one wait state so a preceding write is visible
            hreadyout_reg <= ~(addrTake & ~hwrite);
            hrdata_reg    <= rdStrobe ? readMux : hrdata_reg;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata    = hrdata_reg;
    assign hresp     = 1'b0;
    // ****************************************
    // Control registers
    // ****************************************
    logic [2:0]     pwr_reg;
    logic [1:0]     seqCtl_reg;
    logic [3:0]     tstSel_reg;
    logic           tstMux_reg;
    logic           softRst_reg;

    wire seqWrite  = wrStrobe & isSeq;
    wire testWrite = wrStrobe & isTest & specialMode;
    wire statWrite = wrStrobe & isStatus & specialMode;
    wire clrAll    = softRst_reg;
    wire powerUp   = pwr_reg[PWR_UP_BIT];
    wire fastClr   = pwr_reg[PWR_FAST_CLR_BIT];
    wire scanOn    = seqCtl_reg[SEQ_SCAN_BIT];
    wire eightOn   = seqCtl_reg[SEQ_EIGHT_BIT];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_reg     <= PWR_RESET;
            seqCtl_reg  <= SEQ_RESET;
            tstSel_reg  <= TEST_SEL_RESET;
            tstMux_reg  <= 1'b0;
            softRst_reg <= 1'b0;
        end else if (clrAll) begin
            pwr_reg     <= {2'b00, powerUp};
            seqCtl_reg  <= SEQ_RESET;
            tstSel_reg  <= TEST_SEL_RESET;
            tstMux_reg  <= 1'b0;
            softRst_reg <= 1'b0;
        end else begin
            pwr_reg     <= (wrStrobe & isPower) ? hwdata[2:0] : pwr_reg;
            seqCtl_reg  <= seqWrite ? hwdata[1:0] : seqCtl_reg;
            tstSel_reg  <= testWrite ? hwdata[TEST_SEL_LSB +: 4] : tstSel_reg;
            tstMux_reg  <= testWrite ? hwdata[TEST_MUX_BIT] : tstMux_reg;
            softRst_reg <= testWrite & hwdata[TEST_SOFT_RST_BIT];
        end
    end

    assign testSelect = tstSel_reg;
    assign testOutMux = tstMux_reg;
    // ****************************************
    // Sequencer
    // ****************************************
    adsf_sq_state_t sqState;
    adsf_sq_state_t sqNext;
    logic [11:0]    recCnt_reg;
    logic [2:0]     stepCnt_reg;
    logic [3:0]     bitIdx_reg;
    logic [9:0]     sar_reg;
    logic [2:0]     ptr_reg;
    logic           firstSeq_reg;
    logic           busy_reg;

    wire halted    = ~powerUp | (waitReq & pwr_reg[PWR_STOP_WAIT_BIT]);
    wire abortNow  = seqWrite | stopReq | clrAll;
    wire stepEnd   = (sqState == SQ_CONVERT) & ~halted & ~abortNow &
                     (stepCnt_reg == STEP_LAST);
    wire convDone  = stepEnd & (bitIdx_reg == 4'h0);
    wire lastConv  = (ptr_reg == (eightOn ? 3'h7 : 3'h3));
    wire seqEnd    = convDone & lastConv;
    wire setSeq    = seqEnd & firstSeq_reg;
    wire [9:0] trialVal = compSync_reg ? sar_reg : (sar_reg & ~bitMask(bitIdx_reg));
    wire enterConv = (sqState == SQ_RECOVER) & (sqNext == SQ_CONVERT);

    always_comb begin
        sqNext = sqState;
        unique case (sqState)
            SQ_IDLE: sqNext = sqState;
            SQ_RECOVER: begin
                if (recCnt_reg == 12'h000 && !halted) begin
                    sqNext = SQ_CONVERT;
                end
            end
            SQ_CONVERT: begin
                if (seqEnd && !scanOn) begin
                    sqNext = SQ_IDLE;
                end
            end
        endcase
        if (seqWrite) begin
            sqNext = SQ_RECOVER;
        end
        if (stopReq || clrAll) begin
            sqNext = SQ_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sqState  <= SQ_IDLE;
            busy_reg <= 1'b0;
        end else begin
            sqState  <= sqNext;
            busy_reg <= (sqNext != SQ_IDLE);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            recCnt_reg <= 12'h000;
        end else if (clrAll) begin
            recCnt_reg <= 12'h000;
        end else if (stopReq) begin
            recCnt_reg <= RECOVERY_LOAD;
        end else if (recCnt_reg != 12'h000) begin
            recCnt_reg <= recCnt_reg - 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stepCnt_reg <= 3'h0;
            bitIdx_reg  <= SAR_TOP_BIT;
            sar_reg     <= 10'h000;
        end else if (clrAll) begin
            stepCnt_reg <= 3'h0;
            bitIdx_reg  <= SAR_TOP_BIT;
            sar_reg     <= 10'h000;
        end else if (testWrite) begin
            sar_reg     <= hwdata[9:0];
        end else if (enterConv || convDone) begin
            stepCnt_reg <= 3'h0;
            bitIdx_reg  <= SAR_TOP_BIT;
            sar_reg     <= SAR_START;
        end else if (stepEnd) begin
            stepCnt_reg <= 3'h0;
            bitIdx_reg  <= bitIdx_reg - 4'h1;
            sar_reg     <= trialVal | bitMask(bitIdx_reg - 4'h1);
        end else if (sqState == SQ_CONVERT && !halted) begin
            stepCnt_reg <= stepCnt_reg + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_reg      <= 3'h0;
            firstSeq_reg <= 1'b0;
        end else if (clrAll) begin
            ptr_reg      <= 3'h0;
            firstSeq_reg <= 1'b0;
        end else if (seqWrite) begin
            ptr_reg      <= 3'h0;
            firstSeq_reg <= 1'b1;
        end else if (convDone) begin
            ptr_reg      <= lastConv ? 3'h0 : ptr_reg + 3'h1;
            firstSeq_reg <= firstSeq_reg & ~lastConv;
        end else if (stopReq) begin
            ptr_reg      <= 3'h0;
        end
    end

    assign dacValue   = sar_reg;
    assign channelSel = ptr_reg;
    assign converting = busy_reg;
    // ****************************************
    // Result registers, no reset
    // ****************************************
    logic [9:0]     resultMem [8];

    always_ff @(posedge ref_clk) begin
        if (convDone) begin
            resultMem[ptr_reg] <= trialVal;
        end
    end
    // ****************************************
    // Status flags
    // ****************************************
    logic           seqDone_reg;
    logic [7:0]     ccf_reg;
    logic [7:0]     armed_reg;

    wire rdResult  = rdStrobe & isResult;
    wire rdStatus  = rdStrobe & isStatus;
    wire [7:0] rdOneHot = rdResult ? (8'h01 << dpIdx) : 8'h00;
    wire [7:0] setVec   = convDone ? (8'h01 << ptr_reg) : 8'h00;
    wire [7:0] rdClr    = rdOneHot & (fastClr ? 8'hff : armed_reg);
    wire clrSeqFast     = fastClr & rdResult & (dpIdx == 3'h0);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            seqDone_reg <= 1'b0;
            ccf_reg     <= 8'h00;
            armed_reg   <= 8'h00;
        end else if (clrAll || seqWrite) begin
            seqDone_reg <= 1'b0;
            ccf_reg     <= 8'h00;
            armed_reg   <= 8'h00;
        end else begin
            if (setSeq) begin
                seqDone_reg <= 1'b1;
            end else if (statWrite) begin
                seqDone_reg <= hwdata[STAT_SEQ_DONE_BIT];
            end else if (clrSeqFast) begin
                seqDone_reg <= 1'b0;
            end
            // Set wins over any clear in the same cycle
            ccf_reg   <= setVec | (statWrite ? hwdata[7:0] : (ccf_reg & ~rdClr));
            armed_reg <= rdStatus ? ccf_reg : (armed_reg & ~rdOneHot);
        end
    end
    // ****************************************
    // Read data selection
    // ****************************************
    wire [9:0] resSel = resultMem[dpIdx];
    wire [31:0] statusWord = {16'h0000, seqDone_reg, 4'h0, ptr_reg, ccf_reg};
    wire [31:0] testWord   = specialMode ?
                             {16'h0000, tstSel_reg, tstMux_reg, 1'b0, sar_reg} :
                             32'h0000_0000;
    wire [31:0] resultWord = {16'h0000, resSel, 6'h00};

    assign readMux = isStatus ? statusWord :
                     isTest   ? testWord :
                     isPort   ? {24'h000000, portSync_reg} :
                     isPower  ? {29'h0, pwr_reg} :
                     isSeq    ? {30'h0, seqCtl_reg} :
                     isResult ? resultWord : 32'h0000_0000;
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_seqSet;
        setSeq && !clrAll && !seqWrite |=> seqDone_reg;
    endproperty
    a_seqSet: assert property (p_seqSet) else $error("sequence flag not set at end");
    property p_seqHoldSlow;
        seqDone_reg && !fastClr && !seqWrite && !statWrite && !clrAll |=> seqDone_reg;
    endproperty
    a_seqHoldSlow: assert property (p_seqHoldSlow) else $error("sequence flag lost");
    property p_seqFastClr;
        clrSeqFast && !setSeq && !statWrite && !clrAll && !seqWrite |=> !seqDone_reg;
    endproperty
    a_seqFastClr: assert property (p_seqFastClr) else $error("fast clear missed");
    property p_ptrStep;
        convDone && !lastConv && !clrAll |=> ptr_reg == 3'($past(ptr_reg) + 3'h1);
    endproperty
    a_ptrStep: assert property (p_ptrStep) else $error("pointer did not advance");
    property p_ccfSet;
        convDone && !clrAll |=> ccf_reg[$past(ptr_reg)];
    endproperty
    a_ccfSet: assert property (p_ccfSet) else $error("channel flag not set");
    property p_slowNeedsArm;
        rdResult && !fastClr && !armed_reg[dpIdx] && ccf_reg[dpIdx] && !clrAll
            |=> ccf_reg[$past(dpIdx)];
    endproperty
    a_slowNeedsArm: assert property (p_slowNeedsArm) else $error("flag cleared unarmed");
    property p_testZero;
        rdStrobe && isTest && !specialMode |=> hrdata_reg == 32'h0000_0000;
    endproperty
    a_testZero: assert property (p_testZero) else $error("test read not zero");
    property p_softRst;
        softRst_reg |=> sqState == SQ_IDLE && ccf_reg == 8'h00 &&
                        pwr_reg[PWR_UP_BIT] == $past(pwr_reg[PWR_UP_BIT]);
    endproperty
    a_softRst: assert property (p_softRst) else $error("soft reset incomplete");
    sequence s_stopEnd;
        stopReq ##1 !stopReq;
    endsequence
    property p_recover;
        s_stopEnd |-> (sqState != SQ_CONVERT) [*8];
    endproperty
    a_recover: assert property (p_recover) else $error("converted during recovery");
    property p_portRead;
        rdStrobe && isPort |=> hrdata_reg[7:0] == $past(portSync_reg);
    endproperty
    a_portRead: assert property (p_portRead) else $error("port read mismatch");
    property p_haltHold;
        sqState == SQ_CONVERT && halted && !abortNow && !testWrite |=> $stable(sar_reg);
    endproperty
    a_haltHold: assert property (p_haltHold) else $error("conversion ran while halted");

endmodule
`default_nettype wire

// ### testbench/adsf_analog_model.sv
// Analog channel model: ideal comparator of the selected channel against the trial word
`timescale 1ns/1ps
`default_nettype none

module adsf_analog_model #(
    parameter logic [9:0] LEVELS [8] = '{default: 10'h000}
) (
    input  wire logic [9:0] dacValue,
    input  wire logic [2:0] channelSel,
    output logic            compHigh
);
    // ****************************************
    // Comparator
    // ****************************************
    // High while the channel level is at or above the trial word
    assign compHigh = (LEVELS[channelSel] >= dacValue);
endmodule

`default_nettype wire

// ### testbench/adsf_top_tb_top.sv
// Self-checking testbench of the converter status, flag, test, port and result registers
`timescale 1ns/1ps
`default_nettype none

module adsf_top_tb_top;
    import adsf_pkg::*;
    localparam logic [9:0] LVL [8] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa,
                                       10'h200, 10'h1ff, 10'h001, 10'h3fe};
    logic        ref_clk, rst_b, hsel, hwrite, hreadyout, hresp, specialMode, stopReq;
    logic        waitReq, compHigh, converting, testOutMux;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, channelSel;
    logic [7:0]  portPins;
    logic [9:0]  dacValue;
    logic [3:0]  testSelect;
    int          badCount, totalChecks;

    adsf_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .specialMode(specialMode), .stopReq(stopReq), .waitReq(waitReq),
        .portPins(portPins), .compHigh(compHigh), .dacValue(dacValue),
        .channelSel(channelSel), .converting(converting), .testSelect(testSelect),
        .testOutMux(testOutMux));
    adsf_analog_model #(.LEVELS(LVL)) analog (.dacValue(dacValue),
        .channelSel(channelSel), .compHigh(compHigh));

    // ****************************************
    // Clock, checking and bus tasks
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic finishTest;
        if (badCount == 0 && totalChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Ready and data are registered, so the falling edge shows what the next rise samples
    task automatic waitRdy(output logic [31:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(negedge ref_clk);
        end
        if (n >= 50) begin
            chk("bus ready timeout", 32'h1, 32'h0);
            finishTest();
        end
        d = hrdata;
        @(posedge ref_clk);
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic [31:0] dummy;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        waitRdy(dummy);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(name, r, exp);
    endtask

    task automatic resChk(input int i);
        logic [31:0] r;
        xfer(1'b0, 8'h20 + 8'(4 * i), 32'h0, r);
        chk("result", r & 32'hffff_ffc0, {16'h0, LVL[i], 6'h0});
    endtask

    task automatic waitDone;
        int n;
        n = 0;
        @(negedge ref_clk);
        while (converting !== 1'b0 && n < 4000) begin
            n++;
            @(negedge ref_clk);
        end
        if (n >= 4000) begin
            chk("sequence timeout", 32'h1, 32'h0);
            finishTest();
        end
        @(posedge ref_clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic scPort;
        portPins <= 8'h5a;
        repeat (4) @(posedge ref_clk);
        rdChk("port", ADDR_PORT, 32'h5a);
        wr(ADDR_PORT, 32'ha5);
        chk("okay response", {31'h0, hresp}, 32'h0);
        rdChk("port after write", ADDR_PORT, 32'h5a);
        rdChk("unmapped", 8'h1c, 32'h0);
        rdChk("power reset", ADDR_POWER, 32'h0);
    endtask

    task automatic scTest;
        wr(ADDR_TEST, 32'h0000_a955);
        rdChk("test normal", ADDR_TEST, 32'h0);
        chk("select normal", {28'h0, testSelect}, 32'h0);
        specialMode <= 1'b1;
        wr(ADDR_TEST, 32'h0000_a955);
        rdChk("test special", ADDR_TEST, 32'h0000_a955);
        chk("trial word", {22'h0, dacValue}, 32'h155);
        chk("select", {27'h0, testOutMux, testSelect}, 32'h1a);
        specialMode <= 1'b0;
    endtask

    task automatic scSlow;
        wr(ADDR_POWER, 32'h1);
        wr(ADDR_SEQ, 32'h0);
        waitDone();
        chk("pointer wrapped", {29'h0, channelSel}, 32'h0);
        resChk(2);
        rdChk("flags before status read", ADDR_STATUS, 32'h800f);
        resChk(2);
        rdChk("flag 2 cleared", ADDR_STATUS, 32'h800b);
        for (int i = 0; i < 4; i++) resChk(i);
        rdChk("slow done stays", ADDR_STATUS, 32'h8000);
    endtask

    task automatic scSoft;
        specialMode <= 1'b1;
        wr(ADDR_POWER, 32'h7);
        wr(ADDR_TEST, 32'h0000_f800);
        wr(ADDR_TEST, 32'h0000_f400);
        rdChk("power after soft reset", ADDR_POWER, 32'h1);
        rdChk("status after soft reset", ADDR_STATUS, 32'h0);
        chk("select after soft reset", {27'h0, testOutMux, testSelect}, 32'h0);
        specialMode <= 1'b0;
    endtask

    task automatic scFast;
        wr(ADDR_POWER, 32'h3);
        wr(ADDR_SEQ, 32'h2);
        waitDone();
        rdChk("eight flags", ADDR_STATUS, 32'h80ff);
        resChk(1);
        rdChk("fast flag 1", ADDR_STATUS, 32'h80fd);
        for (int i = 0; i < 8; i++) resChk(i);
        rdChk("fast all clear", ADDR_STATUS, 32'h0);
        wr(ADDR_STATUS, 32'h80ff);
        rdChk("status write normal", ADDR_STATUS, 32'h0);
        specialMode <= 1'b1;
        wr(ADDR_STATUS, 32'h80ff);
        rdChk("status write special", ADDR_STATUS, 32'h80ff);
        specialMode <= 1'b0;
    endtask

    task automatic scScan;
        wr(ADDR_POWER, 32'h1);
        wr(ADDR_SEQ, 32'h1);
        // Status read after nine conversions, then after fourteen
        repeat (380) @(posedge ref_clk);
        chk("scan running", {31'h0, converting}, 32'h1);
        rdChk("scan flags", ADDR_STATUS, 32'h810f);
        resChk(0);
        repeat (200) @(posedge ref_clk);
        rdChk("scan flag again", ADDR_STATUS, 32'h820f);
        wr(ADDR_SEQ, 32'h1);
        rdChk("restart clears", ADDR_STATUS, 32'h0);
        stopReq <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("stop aborts", {31'h0, converting}, 32'h0);
        stopReq <= 1'b0;
        @(posedge ref_clk);
        wr(ADDR_SEQ, 32'h0);
        repeat (1500) @(posedge ref_clk);
        rdChk("recovery delay", ADDR_STATUS, 32'h0);
        waitDone();
        rdChk("after recovery", ADDR_STATUS, 32'h800f);
    endtask

    task automatic scHalt;
        waitReq <= 1'b1;
        wr(ADDR_SEQ, 32'h0);
        waitDone();
        rdChk("wait continues", ADDR_STATUS, 32'h800f);
        wr(ADDR_POWER, 32'h5);
        wr(ADDR_SEQ, 32'h0);
        repeat (300) @(posedge ref_clk);
        rdChk("wait halts", ADDR_STATUS, 32'h0);
        waitReq <= 1'b0;
        waitDone();
        wr(ADDR_SEQ, 32'h0);
        // Power down in the middle of the first conversion
        repeat (20) @(posedge ref_clk);
        wr(ADDR_POWER, 32'h0);
        repeat (300) @(posedge ref_clk);
        rdChk("power down halts", ADDR_STATUS, 32'h0);
        chk("halt keeps sequence", {31'h0, converting}, 32'h1);
        rdChk("power reg reachable", ADDR_POWER, 32'h0);
        wr(ADDR_POWER, 32'h1);
        waitDone();
        rdChk("power up resumes", ADDR_STATUS, 32'h800f);
    endtask

    initial begin
        badCount = 0;
        totalChecks = 0;
        rst_b = 1'b0;
        {hsel, hwrite, specialMode, stopReq, waitReq} = 5'h0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        portPins = 8'h00;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        scPort();
        scTest();
        scSlow();
        scSoft();
        scFast();
        scScan();
        scHalt();
        finishTest();
    end
endmodule

`default_nettype wire
